// [rtl/opc_pad_power_ctrl.sv]
// output pad buffer power control register bank with sleep mask decode
`timescale 1ns/1ps
module opc_pad_power_ctrl #(
	parameter int unsigned FIELD_W   = opc_pkg::FIELD_W,    // width of the pad disable field
	parameter int unsigned DATA_PADS = opc_pkg::DATA_PADS   // number of data pads
) (
	input  wire logic                      ref_clk_i,                 // device clock, 200 MHz
	input  wire logic                      sys_rst_i,                 // asynchronous reset, active high
	// register access from the serial configuration port decoder
	input  wire logic                      reg_wr_i,                  // write strobe, one cycle
	input  wire logic                      reg_rd_i,                  // read strobe, one cycle
	input  wire logic [opc_pkg::ADDR_W-1:0] reg_addr_i,               // register offset
	input  wire logic [opc_pkg::DATA_W-1:0] reg_wdata_i,              // write data
	output logic      [opc_pkg::DATA_W-1:0] reg_rdata_o,              // read data, registered
	output logic                           reg_rvalid_o,              // read data valid, one cycle
	output logic                           reg_hit_o,                 // last access hit a bank register
	// controls held in other registers of the device
	input  wire logic                      global_sleep_i,            // global sleep request
	input  wire logic                      serial_pad_format_i,       // serial output format selected
	input  wire logic                      data_clock_off_i,          // data clock output power-down bit
	input  wire logic                      capture_clock_en_i,        // capture clock input enable bits
	// pad buffer controls
	output logic      [FIELD_W-1:0]        pad_buffer_off_bits_o,     // whole field, one means powered down
	output logic      [DATA_PADS-1:0]      data_pad_off_o,            // data pad buffers by pad number
	output logic                           frame_clock_output_off_o,  // frame clock pad buffer off
	output logic                           data_clock_output_off_o,   // data clock buffer off
	output logic                           capture_clock_input_en_o,  // capture clock input buffer on
	output logic                           capture_pad_conflict_o,    // serial format with shared pad driven
	// internal block power-down levels during global sleep
	output logic                           bias_off_o,                // bias currents off
	output logic                           sample_clk_off_o,          // sampling clock buffer off
	output logic                           ref_amp_off_o,             // reference amplifier off
	output logic                           bandgap_off_o              // bandgap reference off
);

	// address decode
	wire sel_low;
	wire sel_mid;
	wire sel_high;
	wire sel_keep;
	wire sel_any;

	assign sel_low  = (reg_addr_i == opc_pkg::OFS_PAD_OFF_LOW);
	assign sel_mid  = (reg_addr_i == opc_pkg::OFS_PAD_OFF_MID);
	assign sel_high = (reg_addr_i == opc_pkg::OFS_PAD_OFF_HIGH);
	assign sel_keep = (reg_addr_i == opc_pkg::OFS_SLEEP_KEEP);
	assign sel_any  = sel_low | sel_mid | sel_high | sel_keep;

	// write enables per register
	wire wr_low;
	wire wr_mid;
	wire wr_high;
	wire wr_keep;

	assign wr_low  = reg_wr_i & sel_low;
	assign wr_mid  = reg_wr_i & sel_mid;
	assign wr_high = reg_wr_i & sel_high;
	assign wr_keep = reg_wr_i & sel_keep;

	// storage: three disable bytes and the sleep keep mask
	logic [7:0] output_pad_disable_low_r;
	logic [7:0] output_pad_disable_mid_r;
	logic [7:0] output_pad_disable_high_r;
	logic [7:0] sleep_keep_mask_r;

	// next values of the storage
	wire [7:0] output_pad_disable_low_nxt;
	wire [7:0] output_pad_disable_mid_nxt;
	wire [7:0] output_pad_disable_high_nxt;
	wire [7:0] sleep_keep_mask_nxt;

	// every bit is plain read/write, unassigned bits included
	assign output_pad_disable_low_nxt  = wr_low  ? reg_wdata_i : output_pad_disable_low_r;
	assign output_pad_disable_mid_nxt  = wr_mid  ? reg_wdata_i : output_pad_disable_mid_r;
	assign output_pad_disable_high_nxt = wr_high ? reg_wdata_i : output_pad_disable_high_r;
	assign sleep_keep_mask_nxt         = wr_keep ? reg_wdata_i : sleep_keep_mask_r;

	// register update, all buffers enabled after reset
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			output_pad_disable_low_r  <= opc_pkg::RST_PAD_OFF;
			output_pad_disable_mid_r  <= opc_pkg::RST_PAD_OFF;
			output_pad_disable_high_r <= opc_pkg::RST_PAD_OFF;
			sleep_keep_mask_r         <= opc_pkg::RST_SLEEP_KEEP;
		end else begin
			output_pad_disable_low_r  <= output_pad_disable_low_nxt;
			output_pad_disable_mid_r  <= output_pad_disable_mid_nxt;
			output_pad_disable_high_r <= output_pad_disable_high_nxt;
			sleep_keep_mask_r         <= sleep_keep_mask_nxt;
		end
	end

	// read data selection, unmapped offsets read zero
	wire [7:0] rdata_nxt;

	assign rdata_nxt = sel_low  ? output_pad_disable_low_r  :
	                   sel_mid  ? output_pad_disable_mid_r  :
	                   sel_high ? output_pad_disable_high_r :
	                   sel_keep ? sleep_keep_mask_r         :
	                   opc_pkg::RDATA_NONE;

	// read response registers
	logic [7:0] reg_rdata_r;
	logic       reg_rvalid_r;
	logic       reg_hit_r;

	// capture read data one cycle after the strobe
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_r  <= opc_pkg::RDATA_NONE;
			reg_rvalid_r <= 1'b0;
			reg_hit_r    <= 1'b0;
		end else begin
			reg_rdata_r  <= reg_rd_i ? rdata_nxt : reg_rdata_r;
			reg_rvalid_r <= reg_rd_i;
			reg_hit_r    <= (reg_rd_i | reg_wr_i) ? sel_any : reg_hit_r;
		end
	end

	assign reg_rdata_o  = reg_rdata_r;
	assign reg_rvalid_o = reg_rvalid_r;
	assign reg_hit_o    = reg_hit_r;

	// the whole disable field, low byte in the lowest bits
	wire [FIELD_W-1:0] field;

	assign field = {output_pad_disable_high_r, output_pad_disable_mid_r, output_pad_disable_low_r};
	assign pad_buffer_off_bits_o = field;

	// per data pad gate from its field bit
	genvar gi;
	generate
		for (gi = 0; gi < DATA_PADS; gi = gi + 1) begin : g_pad
			// a one powers the pad buffer down
			assign data_pad_off_o[gi] = field[opc_pkg::PAD_BIT[gi]];
		end
	endgenerate

	// frame clock pad from the second register
	assign frame_clock_output_off_o = field[opc_pkg::FRAME_CLOCK_BIT];

	// data clock buffer follows its own bit, never the field
	assign data_clock_output_off_o = data_clock_off_i;

	// capture clock input buffer follows its own enables, never the field
	assign capture_clock_input_en_o = capture_clock_en_i;

	// flag a serial format while the shared pad buffer is still driving
	assign capture_pad_conflict_o = serial_pad_format_i &
	                                ~field[opc_pkg::CAPTURE_SHARED_BIT];

	// sleep decode of the keep mask
	opc_sleep_decode u_sleep (
		.ref_clk_i        (ref_clk_i),
		.sys_rst_i        (sys_rst_i),
		.global_sleep_i   (global_sleep_i),
		.keep_mask_i      (sleep_keep_mask_r),
		.bias_off_o       (bias_off_o),
		.sample_clk_off_o (sample_clk_off_o),
		.ref_amp_off_o    (ref_amp_off_o),
		.bandgap_off_o    (bandgap_off_o)
	);

endmodule : opc_pad_power_ctrl

// [rtl/opc_pkg.sv]
// constants, register map and pad mapping of the output pad buffer power control bank
package opc_pkg;

	// register bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIELD_W = 24;
	localparam int unsigned DATA_PADS = 16;

	// register offsets
	localparam logic [7:0] OFS_PAD_OFF_LOW = 8'h0A;
	localparam logic [7:0] OFS_PAD_OFF_MID = 8'h0B;
	localparam logic [7:0] OFS_PAD_OFF_HIGH = 8'h0C;
	localparam logic [7:0] OFS_SLEEP_KEEP = 8'h0D;

	// reset values
	localparam logic [7:0] RST_PAD_OFF = 8'h00;
	localparam logic [7:0] RST_SLEEP_KEEP = 8'h00;
	localparam logic [7:0] RDATA_NONE = 8'h00;

	// field positions in the low, mid and high byte of the field
	localparam int unsigned LOW_LSB = 0;
	localparam int unsigned MID_LSB = 8;
	localparam int unsigned HIGH_LSB = 16;

	// field bit that shares its pad with the capture clock input
	localparam int unsigned CAPTURE_SHARED_BIT = 3;
	// field bit of the frame clock pad
	localparam int unsigned FRAME_CLOCK_BIT = 12;

	// field bit that gates each data pad, indexed by pad number
	localparam int unsigned PAD_BIT [DATA_PADS] = '{
		0, 1, 2, 3, 4, 20, 21, 7, 8, 22, 23, 17, 16, 15, 14, 13
	};

	// sleep mask field positions
	localparam int unsigned KEEP_BIAS_BIT = 5;
	localparam int unsigned KEEP_SAMPLE_CLK_BIT = 3;
	localparam int unsigned KEEP_REF_AMP_BIT = 2;
	localparam int unsigned BANDGAP_OFF_BIT = 1;
	localparam logic [7:0] SLEEP_KEEP_USED = 8'h2E;

	// recommended settings per output format
	localparam logic [7:0] REC_LOW_SDR = 8'h60;
	localparam logic [7:0] REC_LOW_DDR = 8'h7F;
	localparam logic [7:0] REC_LOW_SERIAL = 8'hFF;
	localparam logic [7:0] REC_MID_SDR = 8'h1E;
	localparam logic [7:0] REC_MID_DDR = 8'hFE;
	localparam logic [7:0] REC_MID_SERIAL = 8'hEF;
	localparam logic [7:0] REC_HIGH_PARALLEL = 8'h0C;
	localparam logic [7:0] REC_HIGH_SERIAL_2W = 8'hFC;
	localparam logic [7:0] REC_HIGH_SERIAL_1W = 8'hFD;

endpackage : opc_pkg

// [rtl/opc_sleep_decode.sv]
// global sleep decode: turns the keep mask and the sleep request into block power-down levels
`timescale 1ns/1ps
module opc_sleep_decode (
	input  wire logic       ref_clk_i,          // device clock
	input  wire logic       sys_rst_i,          // asynchronous reset, active high
	input  wire logic       global_sleep_i,     // global sleep request, same clock domain
	input  wire logic [7:0] keep_mask_i,        // sleep keep mask register contents
	output logic            bias_off_o,         // bias currents powered down
	output logic            sample_clk_off_o,   // sampling clock buffer powered down
	output logic            ref_amp_off_o,      // reference amplifier powered down
	output logic            bandgap_off_o       // bandgap reference powered down
);

	// mask fields, only the assigned positions are looked at
	wire keep_bias_on;
	wire keep_sample_clock_buffer;
	wire keep_reference_amplifier;
	wire bandgap_off_in_sleep;

	assign keep_bias_on             = keep_mask_i[opc_pkg::KEEP_BIAS_BIT];
	assign keep_sample_clock_buffer = keep_mask_i[opc_pkg::KEEP_SAMPLE_CLK_BIT];
	assign keep_reference_amplifier = keep_mask_i[opc_pkg::KEEP_REF_AMP_BIT];
	assign bandgap_off_in_sleep     = keep_mask_i[opc_pkg::BANDGAP_OFF_BIT];

	// next power-down levels
	wire bias_off_nxt;
	wire sample_clk_off_nxt;
	wire ref_amp_off_nxt;
	wire bandgap_off_nxt;

	// keep bits hold their block up while asleep
	assign bias_off_nxt       = global_sleep_i & ~keep_bias_on;
	assign sample_clk_off_nxt = global_sleep_i & ~keep_sample_clock_buffer;
	assign ref_amp_off_nxt    = global_sleep_i & ~keep_reference_amplifier;
	// bandgap bit has the opposite sense: one lets it drop, slower wake-up
	assign bandgap_off_nxt    = global_sleep_i & bandgap_off_in_sleep;

	// power-down levels from flip-flops, all blocks up after reset
	logic bias_off_r;
	logic sample_clk_off_r;
	logic ref_amp_off_r;
	logic bandgap_off_r;

	// register the levels
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bias_off_r       <= 1'b0;
			sample_clk_off_r <= 1'b0;
			ref_amp_off_r    <= 1'b0;
			bandgap_off_r    <= 1'b0;
		end else begin
			bias_off_r       <= bias_off_nxt;
			sample_clk_off_r <= sample_clk_off_nxt;
			ref_amp_off_r    <= ref_amp_off_nxt;
			bandgap_off_r    <= bandgap_off_nxt;
		end
	end

	assign bias_off_o       = bias_off_r;
	assign sample_clk_off_o = sample_clk_off_r;
	assign ref_amp_off_o    = ref_amp_off_r;
	assign bandgap_off_o    = bandgap_off_r;

endmodule : opc_sleep_decode

// [verif/opc_pad_power_chk.sv]
// assertion checker for the output pad buffer power control bank
`timescale 1ns/1ps
module opc_pad_power_chk #(
	parameter int unsigned FIELD_W   = 24,  // pad disable field width
	parameter int unsigned DATA_PADS = 16   // data pad count
) (
	input wire logic                         ref_clk_i,
	input wire logic                         sys_rst_i,
	input wire logic                         reg_wr_i,
	input wire logic                         reg_rd_i,
	input wire logic [opc_pkg::ADDR_W-1:0]   reg_addr_i,
	input wire logic [opc_pkg::DATA_W-1:0]   reg_wdata_i,
	input wire logic [opc_pkg::DATA_W-1:0]   reg_rdata_o,
	input wire logic                         reg_rvalid_o,
	input wire logic                         reg_hit_o,
	input wire logic                         global_sleep_i,
	input wire logic                         data_clock_off_i,
	input wire logic                         capture_clock_en_i,
	input wire logic [FIELD_W-1:0]           pad_buffer_off_bits_o,
	input wire logic [DATA_PADS-1:0]         data_pad_off_o,
	input wire logic                         frame_clock_output_off_o,
	input wire logic                         data_clock_output_off_o,
	input wire logic                         capture_clock_input_en_o,
	input wire logic                         bias_off_o,
	input wire logic                         sample_clk_off_o,
	input wire logic                         ref_amp_off_o,
	input wire logic                         bandgap_off_o
);
	// all checks on the device clock, quiet in reset
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// a write strobe aimed at one offset
	sequence wr_at(logic [7:0] a);
		reg_wr_i && reg_addr_i == a;
	endsequence
	wr_low_a : assert property (wr_at(8'h0A) |=> pad_buffer_off_bits_o[7:0] == $past(reg_wdata_i))
		else $error("low disable byte not stored");
	wr_mid_a : assert property (wr_at(8'h0B) |=> pad_buffer_off_bits_o[15:8] == $past(reg_wdata_i))
		else $error("mid disable byte not stored");
	wr_high_a : assert property (wr_at(8'h0C) |=> pad_buffer_off_bits_o[23:16] == $past(reg_wdata_i))
		else $error("high disable byte not stored");
	field_hold_a : assert property (!reg_wr_i |=> $stable(pad_buffer_off_bits_o))
		else $error("disable field moved without a write");
	read_valid_a : assert property (1'b1 |=> reg_rvalid_o == $past(reg_rd_i))
		else $error("read valid not one cycle after strobe");
	unmapped_read_a : assert property (reg_rd_i && !(reg_addr_i inside {[8'h0A:8'h0D]})
		|=> reg_rdata_o == 8'h00 && !reg_hit_o)
		else $error("unmapped read not empty");
	pad_map_a : assert property (data_pad_off_o == {pad_buffer_off_bits_o[13], pad_buffer_off_bits_o[14],
		pad_buffer_off_bits_o[15], pad_buffer_off_bits_o[16], pad_buffer_off_bits_o[17],
		pad_buffer_off_bits_o[23], pad_buffer_off_bits_o[22], pad_buffer_off_bits_o[8:7],
		pad_buffer_off_bits_o[21], pad_buffer_off_bits_o[20], pad_buffer_off_bits_o[4:0]})
		else $error("data pad gating map wrong");
	frame_pad_a : assert property (frame_clock_output_off_o == pad_buffer_off_bits_o[12])
		else $error("frame clock pad not on field bit");
	data_clock_output_free_a : assert property (data_clock_output_off_o == data_clock_off_i)
		else $error("data clock buffer not from its own bit");
	capture_en_a : assert property (capture_clock_input_en_o == capture_clock_en_i)
		else $error("capture clock input enable not passed");
	awake_blocks_a : assert property (!global_sleep_i |=> !bias_off_o && !sample_clk_off_o && !ref_amp_off_o
		&& !bandgap_off_o)
		else $error("block powered down without global sleep");
endmodule : opc_pad_power_chk
bind opc_pad_power_ctrl opc_pad_power_chk #(.FIELD_W(FIELD_W), .DATA_PADS(DATA_PADS)) i_opc_pad_power_chk (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .reg_hit_o(reg_hit_o), .global_sleep_i(global_sleep_i),
	.data_clock_off_i(data_clock_off_i), .capture_clock_en_i(capture_clock_en_i),
	.pad_buffer_off_bits_o(pad_buffer_off_bits_o), .data_pad_off_o(data_pad_off_o),
	.frame_clock_output_off_o(frame_clock_output_off_o), .data_clock_output_off_o(data_clock_output_off_o),
	.capture_clock_input_en_o(capture_clock_input_en_o), .bias_off_o(bias_off_o),
	.sample_clk_off_o(sample_clk_off_o), .ref_amp_off_o(ref_amp_off_o), .bandgap_off_o(bandgap_off_o));

// [verif/opc_tb.sv]
// self-checking testbench of the output pad buffer power control bank
`timescale 1ns/1ps
module testbench;
	typedef struct { logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp; } opc_row_t;
	logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d;
	logic global_sleep_i = 1'b0, serial_pad_format_i = 1'b0, data_clock_off_i = 1'b0, capture_clock_en_i = 1'b0;
	logic [23:0] pad_buffer_off_bits_o, f = 24'h000000;
	logic [15:0] data_pad_off_o, p;
	logic reg_rvalid_o, reg_hit_o, frame_clock_output_off_o, data_clock_output_off_o, capture_clock_input_en_o;
	logic capture_pad_conflict_o, bias_off_o, sample_clk_off_o, ref_amp_off_o, bandgap_off_o;
	int mismatches = 0, comparisons = 0;
	// field bit of each data pad, pad 0 first
	int map [16] = '{0, 1, 2, 3, 4, 20, 21, 7, 8, 22, 23, 17, 16, 15, 14, 13};
	// recommended settings per format, then a sleep mask of the used bits and one of the reserved bits
	opc_row_t rows [11] = '{'{8'h0A, 8'h60, 8'h60}, '{8'h0B, 8'h1E, 8'h1E}, '{8'h0C, 8'h0C, 8'h0C},
		'{8'h0A, 8'h7F, 8'h7F}, '{8'h0B, 8'hFE, 8'hFE}, '{8'h0A, 8'hFF, 8'hFF}, '{8'h0B, 8'hEF, 8'hEF},
		'{8'h0C, 8'hFC, 8'hFC}, '{8'h0C, 8'hFD, 8'hFD}, '{8'h0D, 8'h2E, 8'h2E}, '{8'h0D, 8'hD1, 8'hD1}};
	opc_pad_power_ctrl i_opc_pad_power_ctrl (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .reg_hit_o(reg_hit_o), .global_sleep_i(global_sleep_i),
		.serial_pad_format_i(serial_pad_format_i), .data_clock_off_i(data_clock_off_i),
		.capture_clock_en_i(capture_clock_en_i), .pad_buffer_off_bits_o(pad_buffer_off_bits_o),
		.data_pad_off_o(data_pad_off_o), .frame_clock_output_off_o(frame_clock_output_off_o),
		.data_clock_output_off_o(data_clock_output_off_o), .capture_clock_input_en_o(capture_clock_input_en_o),
		.capture_pad_conflict_o(capture_pad_conflict_o), .bias_off_o(bias_off_o),
		.sample_clk_off_o(sample_clk_off_o), .ref_amp_off_o(ref_amp_off_o), .bandgap_off_o(bandgap_off_o));
	// 200 MHz device clock
	always #2.5 ref_clk_i = ~ref_clk_i;
	// one compare for every kind of value, widened to the field
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one-cycle write strobe, settles past the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask : wr
	// one-cycle read strobe, answer one cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("rvalid", 24'h1, reg_rvalid_o);
		v = reg_rdata_o;
	endtask : rd
	// verdict and end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	// cut a hang short
	initial begin
		#20000;
		mismatches++;
		final_report();
	end
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		for (int a = 8'h0A; a <= 8'h0D; a++) begin
			rd(8'(a), d);
			chk("reset value", 24'h0, d);
		end
		chk("reset field", 24'h0, pad_buffer_off_bits_o);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			if (rows[i].addr != 8'h0D) f[(rows[i].addr - 8'h0A) * 8 +: 8] = rows[i].wdata;
			for (int n = 0; n < 16; n++) p[n] = f[map[n]];
			chk("field", f, pad_buffer_off_bits_o);
			chk("pads", p, data_pad_off_o);
			chk("frame pad", f[12], frame_clock_output_off_o);
			rd(rows[i].addr, d);
			chk("readback", rows[i].rexp, d);
		end
		$display("test rows done");
		global_sleep_i <= 1'b1;
		@(posedge ref_clk_i);
		@(posedge ref_clk_i);
		#1;
		chk("sleep mask clear", 24'hE, {bias_off_o, sample_clk_off_o, ref_amp_off_o, bandgap_off_o});
		wr(8'h0D, 8'h2E);
		@(posedge ref_clk_i);
		#1;
		chk("sleep mask set", 24'h1, {bias_off_o, sample_clk_off_o, ref_amp_off_o, bandgap_off_o});
		global_sleep_i <= 1'b0;
		$display("test sleep done");
		wr(8'h0E, 8'h55);
		rd(8'h0E, d);
		chk("unmapped read", 24'h0, {d, reg_hit_o});
		chk("field after unmapped write", f, pad_buffer_off_bits_o);
		serial_pad_format_i <= 1'b1;
		data_clock_off_i <= 1'b1;
		capture_clock_en_i <= 1'b1;
		wr(8'h0A, 8'hF7);
		chk("shared pad conflict", 24'h1, capture_pad_conflict_o);
		chk("other buffers", 24'h3, {data_clock_output_off_o, capture_clock_input_en_o});
		wr(8'h0A, 8'hFF);
		chk("shared pad off", 24'h0, capture_pad_conflict_o);
		$display("test awkward done");
		sys_rst_i <= 1'b1;
		@(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd(8'h0B, d);
		chk("mid-run reset", 24'h0, {d, pad_buffer_off_bits_o});
		$display("test second reset done");
		final_report();
	end
endmodule : testbench
